/* File: hw/sar_readout_pkg.sv */
// Shared constants for the serial conversion readout block
package sar_readout_pkg;
    localparam int RESULT_BITS = 16;
    localparam logic [4:0] ACQ_LAST_FALL = 5'h04;
    localparam logic [4:0] MSB_INDEX = 5'h0f;
    localparam logic [4:0] LSB_INDEX = 5'h00;
    localparam logic [4:0] REPEAT_FIRST = 5'h01;
    localparam logic [4:0] REPEAT_END = 5'h10;
    localparam logic [4:0] INDEX_ZERO = 5'h00;
    localparam logic [RESULT_BITS-1:0] TRIAL_START = 16'h8000;
    localparam logic [RESULT_BITS-1:0] CODE_ZERO = 16'h0000;
    localparam int MIN_CYCLE_CLOCKS = 22;
    localparam real CONV_CLK_MIN_KHZ = 24.0;
    localparam real CONV_CLK_MAX_MHZ = 6.0;

    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_acquire = 3'h1,
        st_null = 3'h3,
        st_convert = 3'h2,
        st_repeat = 3'h6,
        st_done = 3'h7
    } cycle_state_e;
endpackage

/* File: hw/sar_register.sv */
// Successive approximation register with trial code for the capacitor DAC
`timescale 1ns/1ps
module sar_register
    import sar_readout_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic step,
    input wire logic cmp_high,
    output logic [RESULT_BITS-1:0] trial_code
);
    logic [RESULT_BITS-1:0] mask;
    logic [RESULT_BITS-1:0] next_code;

    // Keep the trial bit when the input is above it, then try the next bit down
    assign next_code = (cmp_high ? trial_code : (trial_code & ~mask)) | (mask >> 1);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trial_code <= CODE_ZERO;
            mask <= CODE_ZERO;
        end else if (start) begin
            trial_code <= TRIAL_START;
            mask <= TRIAL_START;
        end else if (step && (mask != CODE_ZERO)) begin
            trial_code <= next_code;
            mask <= mask >> 1;
        end
    end
endmodule

/* File: hw/sar_conversion_readout.sv */
// Conversion cycle sequencer and serial result readout
`timescale 1ns/1ps
module sar_conversion_readout
    import sar_readout_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic select_or_powerdown_n,
    input wire logic conversion_shift_clock,
    input wire logic cmp_high,
    output logic dout,
    output logic dout_oe_n,
    output logic sample_on,
    output logic input_isolate,
    output logic trim_reload,
    output logic [RESULT_BITS-1:0] dac_code
);
    // ************************************************************
    // Edge detection and decode
    // ************************************************************
    cycle_state_e state;
    cycle_state_e next_state;
    logic sclk_prev;
    logic sel_prev;
    logic [4:0] index;
    logic [4:0] next_index;
    logic next_dout;
    logic next_oe_n;
    wire sclk_fall = sclk_prev & ~conversion_shift_clock;
    wire sel_fall = sel_prev & ~select_or_powerdown_n;
    wire sel_high = select_or_powerdown_n;
    wire acq_end = sclk_fall && (state == st_acquire) && (index == ACQ_LAST_FALL);
    wire msb_step = (index == MSB_INDEX);
    wire sar_step = sclk_fall && ((state == st_null) || (state == st_convert));
    // Offset binary from the DAC becomes two's complement by flipping the top bit
    wire [RESULT_BITS-1:0] result_tc = {~dac_code[RESULT_BITS-1], dac_code[RESULT_BITS-2:0]};
    wire live_bit = msb_step ? ~cmp_high : cmp_high;
    wire repeat_bit = result_tc[index[3:0]];

    assign sample_on = (state == st_acquire);
    assign input_isolate = (state == st_null) || (state == st_convert);

    sar_register u_sar (
        .clk(clk),
        .rstn(rstn),
        .start(acq_end),
        .step(sar_step),
        .cmp_high(cmp_high),
        .trial_code(dac_code)
    );

    // ************************************************************
    // Cycle sequencing
    // ************************************************************
    always_comb begin
        next_state = state;
        next_index = index;
        next_dout = dout;
        next_oe_n = dout_oe_n;
        if (sel_high) begin
            // Raising select ends the cycle at once, mid-word or not
            next_state = st_idle;
            next_oe_n = 1'b1;
            next_dout = 1'b0;
        end else if (sel_fall || state == st_idle) begin
            next_state = st_acquire;
            next_index = INDEX_ZERO;
        end else if (sclk_fall) begin
            unique case (state)
                st_acquire: begin
                    if (index == ACQ_LAST_FALL) begin
                        next_state = st_null;
                        next_oe_n = 1'b0;
                        next_dout = 1'b0;
                        next_index = MSB_INDEX;
                    end else begin
                        next_index = index + 5'h01;
                    end
                end
                st_null, st_convert: begin
                    next_dout = live_bit;
                    if (index == LSB_INDEX) begin
                        next_state = st_repeat;
                        next_index = REPEAT_FIRST;
                    end else begin
                        next_state = st_convert;
                        next_index = index - 5'h01;
                    end
                end
                st_repeat: begin
                    if (index == REPEAT_END) begin
                        next_state = st_done;
                        next_oe_n = 1'b1;
                        next_dout = 1'b0;
                    end else begin
                        next_dout = repeat_bit;
                        next_index = index + 5'h01;
                    end
                end
                st_done: next_state = st_done;
                st_idle: next_state = st_acquire;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= st_idle;
            index <= INDEX_ZERO;
            dout <= 1'b0;
            dout_oe_n <= 1'b1;
            trim_reload <= 1'b0;
            sclk_prev <= 1'b0;
            sel_prev <= 1'b1;
        end else begin
            state <= next_state;
            index <= next_index;
            dout <= next_dout;
            dout_oe_n <= next_oe_n;
            trim_reload <= acq_end && !sel_high;
            sclk_prev <= conversion_shift_clock;
            sel_prev <= select_or_powerdown_n;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_acq_to_null;
        @(posedge clk) disable iff (!rstn)
        (acq_end && !sel_high) |=> (state == st_null) && !dout_oe_n && !dout;
    endproperty
    a_acq_to_null: assert property (p_acq_to_null) else $error("null bit missing");

    property p_trim_after_acq;
        @(posedge clk) disable iff (!rstn)
        trim_reload |-> ($past(state) == st_acquire) && (state == st_null);
    endproperty
    a_trim_after_acq: assert property (p_trim_after_acq) else $error("trim reload misplaced");

    property p_sel_start;
        @(posedge clk) disable iff (!rstn)
        sel_fall |=> (state == st_acquire) && sample_on && dout_oe_n;
    endproperty
    a_sel_start: assert property (p_sel_start) else $error("select fall did not start");

    property p_sel_release;
        @(posedge clk) disable iff (!rstn)
        sel_high |=> dout_oe_n && (state == st_idle);
    endproperty
    a_sel_release: assert property (p_sel_release) else $error("output not released");

    property p_isolate;
        @(posedge clk) disable iff (!rstn)
        !(sample_on && input_isolate);
    endproperty
    a_isolate: assert property (p_isolate) else $error("input sampled while isolated");

    property p_msb_first;
        @(posedge clk) disable iff (!rstn)
        (sclk_fall && state == st_null && !sel_high) |=> (dout == ~$past(cmp_high)) && !dout_oe_n;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("msb not current result");

    property p_repeat_bits;
        @(posedge clk) disable iff (!rstn)
        (sclk_fall && state == st_repeat && index != REPEAT_END && !sel_high)
            |=> dout == $past(repeat_bit);
    endproperty
    a_repeat_bits: assert property (p_repeat_bits) else $error("lsb first repeat wrong");

    property p_done_quiet;
        @(posedge clk) disable iff (!rstn)
        (state == st_done && !sel_high) |=> dout_oe_n && (state == st_done || state == st_idle);
    endproperty
    a_done_quiet: assert property (p_done_quiet) else $error("clocks not ignored");

    property p_acq_five;
        @(posedge clk) disable iff (!rstn)
        (state == st_acquire && sclk_fall && index < ACQ_LAST_FALL && !sel_high)
            |=> state == st_acquire;
    endproperty
    a_acq_five: assert property (p_acq_five) else $error("acquisition cut short");

    // The trim pulse and the midscale trial code come from the same fall, so they must line up
    property p_trim_code;
        @(posedge clk) disable iff (!rstn)
        trim_reload |-> (dac_code == TRIAL_START) && input_isolate && !sample_on;
    endproperty
    a_trim_code: assert property (p_trim_code) else $error("trial code not at midscale");

    property p_released_low;
        @(posedge clk) disable iff (!rstn)
        dout_oe_n |-> !dout;
    endproperty
    a_released_low: assert property (p_released_low) else $error("data driven while off");

    property p_idle_quiet;
        @(posedge clk) disable iff (!rstn)
        (state == st_idle) |-> dout_oe_n && !sample_on && !input_isolate;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("idle not quiet");

    property p_convert_count;
        @(posedge clk) disable iff (!rstn)
        (sclk_fall && state == st_convert && index != LSB_INDEX && !sel_high)
            |=> (state == st_convert) && (index == $past(index) - 5'h01);
    endproperty
    a_convert_count: assert property (p_convert_count) else $error("bit count skipped");

    // Leaving the last result bit must hand over to the repeat word with the pins still driven
    property p_enter_repeat;
        @(posedge clk) disable iff (!rstn)
        (sar_step && index == LSB_INDEX && !sel_high)
            |=> (state == st_repeat) && !dout_oe_n && !input_isolate;
    endproperty
    a_enter_repeat: assert property (p_enter_repeat) else $error("repeat word not entered");
endmodule

/* File: dv/sar_master_model.sv */
// Serial master and comparator model facing the readout block
`timescale 1ns/1ps
module sar_master_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [5:0] n_falls,
    input wire logic [15:0] code,
    input wire logic dout,
    input wire logic dout_oe_n,
    output logic sel_n,
    output logic sclk,
    output logic cmp_high,
    output logic busy,
    output logic [63:0] got_d,
    output logic [63:0] got_oe
);
    // ****************************************
    // Four clk per conversion clock, 25 MHz
    // ****************************************
    logic [1:0] ph;
    logic [5:0] f;
    initial begin
        sel_n = 1'b1;
        sclk = 1'b1;
        cmp_high = 1'b0;
        busy = 1'b0;
        ph = 2'h0;
        f = 6'h00;
    end
    always @(posedge clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            sel_n <= 1'b0;
            ph <= 2'h2;
            f <= 6'h00;
        end else if (busy) begin
            ph <= ph + 2'h1;
            if (ph == 2'h3) begin
                sclk <= 1'b1;
            end
            if (ph == 2'h1) begin
                // Sample one full period after the fall, when the bit has settled
                got_d[f] <= dout;
                got_oe[f] <= dout_oe_n;
                if (f < n_falls) begin
                    sclk <= 1'b0;
                    f <= f + 6'h01;
                    cmp_high <= (f == 6'h05) ? ~code[15] :
                        (f > 6'h05 && f < 6'h15) ? code[4'(6'h14 - f)] : 1'b0;
                end else begin
                    sel_n <= 1'b1;
                    busy <= 1'b0;
                end
            end
        end
    end
endmodule

/* File: dv/test_sar_conversion_readout.sv */
// Testbench for the serial conversion readout block
`timescale 1ns/1ps
module test_sar_conversion_readout;
    import sar_readout_pkg::*;
    logic clk, rstn, go, sel_n, sclk, cmp, dout, oe_n, smp, iso, trim, busy;
    logic [15:0] dac, code;
    logic [5:0] n_falls;
    logic [63:0] got_d, got_oe;
    logic [15:0] codes [5] = '{16'h7fff, 16'h8000, 16'h0000, 16'hffff, 16'ha5c3};
    int failures, samples_checked, trims, smp_seen, iso_seen;
    sar_conversion_readout u_sar_conversion_readout (.clk(clk), .rstn(rstn),
        .select_or_powerdown_n(sel_n), .conversion_shift_clock(sclk), .cmp_high(cmp),
        .dout(dout), .dout_oe_n(oe_n), .sample_on(smp), .input_isolate(iso),
        .trim_reload(trim), .dac_code(dac));
    sar_master_model u_sar_master_model (.clk(clk), .go(go), .n_falls(n_falls),
        .code(code), .dout(dout), .dout_oe_n(oe_n), .sel_n(sel_n), .sclk(sclk),
        .cmp_high(cmp), .busy(busy), .got_d(got_d), .got_oe(got_oe));
    // ****************************************
    // Clock, monitors and checking
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (trim === 1'b1) trims++;
        if (smp === 1'b1) smp_seen = 1;
        if (iso === 1'b1) iso_seen = 1;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic run(input logic [15:0] c, input logic [5:0] n);
        int k = 0;
        code <= c;
        n_falls <= n;
        trims = 0;
        smp_seen = 0;
        iso_seen = 0;
        @(posedge clk) go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        // Busy only shows after the edge that took go, so look one edge later
        do @(posedge clk); while (busy !== 1'b0 && ++k < 2000);
        if (k >= 2000) failures++;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic full_cycle(input logic [15:0] c);
        run(c, 6'h28);
        check(got_oe[4], 1'b1);
        check(got_oe[5], 1'b0);
        check(got_d[5], 1'b0);
        for (int i = 0; i < 16; i++) begin
            check(got_d[6 + i], c[15 - i]);
        end
        for (int j = 0; j < 15; j++) begin
            check(got_d[22 + j], c[1 + j]);
        end
        for (int i = 37; i < 41; i++) begin
            check({got_oe[i], got_d[i]}, 2'b10);
        end
        check(16'(trims), 16'h0001);
        check(16'(smp_seen), 16'h0001);
        check(16'(iso_seen), 16'h0001);
        check(dac, c ^ 16'h8000);
    endtask
    task automatic abort_cycle();
        run(16'h1234, 6'h0c);
        check(got_oe[12], 1'b0);
        repeat (2) @(posedge clk);
        check({oe_n, dout}, 2'b10);
    endtask
    initial begin
        rstn = 1'b0;
        go = 1'b0;
        code = 16'h0000;
        n_falls = 6'h00;
        failures = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        foreach (codes[i]) full_cycle(codes[i]);
        abort_cycle();
        full_cycle(16'h5a3c);
        close_out();
    end
    // Whole run is near 1100 clk; the watchdog allows about eighteen times that
    initial begin
        #200000;
        failures++;
        close_out();
    end
endmodule
